/* hdl/uib_bidding.sv */
// Interrupt bidding, capture and global register logic with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Eighteen sources: four rx, four tx, four break, four state change, two timers.
// - Every clock the winning bid is compared against the programmed threshold.
// - Interrupt request rises only when a bid exceeds the threshold.
// - Capture register loads only on acknowledge or on the refresh command.
// - Captured bid encodes channel, type and byte count in one read.
// - Captured value drives vector modification and global register selection.
// - Global receive read returns the captured channel's receive FIFO byte.
// - Global transmit write sends the byte to the captured channel's FIFO.
// - Global count and channel reads return those captured fields right justified.
// - Global locations store nothing; each access decodes from the capture register.
// - Rx error bid: full bit 7, count 6:5, ones 4:2, channel 1:0.
// - Rx bid without error: same layout but bit 4 is zero.
// - Bits 4:2 give the source type code, except in transmitter bids, where bit 4 is part of the free count.
// - Largest bid wins; on equal upper bits the highest channel wins.
// - Six bit threshold compares only the upper six bid bits.
// - Idle timer, empty receiver or full transmitter never bids.
module uib_bidding import uib_pkg::*; #(
  parameter int CH_COUNT = NUM_CH,
  parameter int CT_COUNT = NUM_CT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Receiver sources
  input wire logic [NUM_CH-1:0] rx_nonempty,
  input wire logic [NUM_CH-1:0] rx_full,
  input wire logic [NUM_CH-1:0] rx_error,
  input wire logic [2*NUM_CH-1:0] rx_count,
  input wire logic [8*NUM_CH-1:0] rx_fifo_data,
  // Transmitter sources
  input wire logic [NUM_CH-1:0] tx_not_full,
  input wire logic [3*NUM_CH-1:0] tx_free,
  // Other sources
  input wire logic [NUM_CH-1:0] break_active,
  input wire logic [NUM_CH-1:0] cos_active,
  input wire logic [NUM_CT-1:0] ct_timeout,
  // Interrupt acknowledge
  input wire logic intr_acknowledge_low,
  // Interrupt outputs
  output logic irq_request,
  output logic irq,
  output logic [7:0] vector,
  // Global FIFO access
  output logic rx_pop,
  output logic [1:0] rx_pop_ch,
  output logic tx_push,
  output logic [1:0] tx_push_ch,
  output logic [7:0] tx_push_data
);
  localparam int NUM_SRC = 4*NUM_CH + NUM_CT;

  uib_state_type st_r;
  uib_state_type st_nxt;
  logic [BID_W-1:0] bid [NUM_SRC];
  logic [BID_W-1:0] win;
  logic [BID_W-1:0] win_gated;
  logic [7:0] grx_byte;
  logic over;
  logic take;
  logic dwr;
  logic drd;
  logic refresh;
  logic cap_ev;

  if (CH_COUNT != NUM_CH || CT_COUNT != NUM_CT) begin : g_chk
    $error("Only four channels and two counter/timers are supported");
  end

  // Right justified byte count of a bid
  function automatic logic [2:0] uib_count(input logic [BID_W-1:0] b);
    logic [2:0] c;
    c = {1'b0, b[6:5]};
    if (b[3:2] == TX_TAIL) begin
      c = b[6:4];
    end
    return c;
  endfunction

  // Vector with captured fields folded in
  function automatic logic [7:0] uib_vec(input uib_vmode_type m, input logic [7:0] base,
                                        input logic [BID_W-1:0] b);
    logic [7:0] v;
    unique case (m)
      VM_NONE: v = base;
      VM_CHAN: v = {base[7:2], b[1:0]};
      VM_TYPE: v = {base[7:5], b[4:0]};
      default: v = base;
    endcase
    return v;
  endfunction

  // ****************************************
  // Bid encoding
  // ****************************************
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam logic [1:0] CH = 2'(i);
    assign bid[i] = (rx_nonempty[i] && st_r.src_en[i]) ?
      {rx_full[i], rx_count[2*i +: 2], rx_error[i], RX_TAIL, CH} : '0;
    assign bid[NUM_CH+i] = (tx_not_full[i] && st_r.src_en[NUM_CH+i]) ?
      {1'b0, tx_free[3*i +: 3], TX_TAIL, CH} : '0;
    assign bid[2*NUM_CH+i] = (break_active[i] && st_r.src_en[2*NUM_CH+i]) ?
      {1'b1, st_r.prio[2*i +: 2], TYPE_BRK, CH} : '0;
    assign bid[3*NUM_CH+i] = (cos_active[i] && st_r.src_en[3*NUM_CH+i]) ?
      {1'b1, st_r.prio[PRIO_COS_LSB+2*i +: 2], TYPE_COS, CH} : '0;
  end

  for (genvar j = 0; j < NUM_CT; j++) begin : g_ct
    localparam logic [1:0] CH = 2'(j);
    assign bid[4*NUM_CH+j] = (ct_timeout[j] && st_r.src_en[4*NUM_CH+j]) ?
      {st_r.prio[PRIO_CT_LSB+2*j +: 2], 1'b0, TYPE_CT, CH} : '0;
  end

  // ****************************************
  // Arbitration and threshold
  // ****************************************
  always_comb begin
    win = '0;
    for (int k = 0; k < NUM_SRC; k++) begin
      if (bid[k] > win) begin
        win = bid[k];
      end
    end
  end

  assign over = win[BID_W-1:2] > st_r.thr;
  assign win_gated = over ? win : '0;

  // ****************************************
  // Bus and capture
  // ****************************************
  assign take = st_r.ph == BUS_IDLE && hsel && hready && htrans[1];
  assign dwr = st_r.ph == BUS_DATA && st_r.wr;
  assign drd = st_r.ph == BUS_DATA && !st_r.wr;
  assign refresh = dwr && st_r.addr == OFS_CAP;
  assign cap_ev = (st_r.ack_d && !intr_acknowledge_low) || refresh;
  assign grx_byte = rx_fifo_data[8*st_r.cap[1:0] +: 8];

  always_comb begin
    logic [1:0] clr;
    logic [1:0] set;
    clr = '0;
    set = '0;
    st_nxt = st_r;
    st_nxt.rx_pop = 1'b0;
    st_nxt.tx_push = 1'b0;
    st_nxt.ack_d = intr_acknowledge_low;
    st_nxt.req = over;
    set[STAT_REQ] = over && !st_r.req;
    set[STAT_CAP] = cap_ev;
    if (cap_ev) begin
      st_nxt.cap = win_gated;
      st_nxt.vec = uib_vec(st_r.vmode, st_r.vbase, win_gated);
    end
    unique case (st_r.ph)
      BUS_IDLE: begin
        if (take) begin
          st_nxt.ph = BUS_DATA;
          st_nxt.wr = hwrite;
          st_nxt.addr = haddr[7:0];
          st_nxt.hready = 1'b0;
        end
      end
      BUS_DATA: begin
        st_nxt.ph = BUS_IDLE;
        st_nxt.hready = 1'b1;
        if (st_r.wr) begin
          case (st_r.addr)
            OFS_CTRL: begin
              st_nxt.thr = hwdata[THR_W-1:0];
              st_nxt.vmode = uib_vmode_type'(hwdata[CTRL_VMODE_LSB +: 2]);
              st_nxt.vbase = hwdata[CTRL_VBASE_LSB +: 8];
            end
            OFS_PRIO: st_nxt.prio = hwdata[PRIO_W-1:0];
            OFS_SRC_EN: st_nxt.src_en = hwdata[NUM_SRC-1:0];
            OFS_GTX: begin
              st_nxt.tx_push = 1'b1;
              st_nxt.tx_ch = st_r.cap[1:0];
              st_nxt.tx_data = hwdata[7:0];
            end
            OFS_STAT: clr = hwdata[1:0];
            OFS_MASK: st_nxt.mask = hwdata[1:0];
            default: ;
          endcase
        end else begin
          case (st_r.addr)
            OFS_CTRL: st_nxt.rdata = {16'h0, st_r.vbase, st_r.vmode, st_r.thr};
            OFS_PRIO: st_nxt.rdata = {12'h0, st_r.prio};
            OFS_SRC_EN: st_nxt.rdata = {14'h0, st_r.src_en};
            OFS_CAP: st_nxt.rdata = {24'h0, st_r.cap};
            OFS_GBYTE: st_nxt.rdata = {29'h0, uib_count(st_r.cap)};
            OFS_GCHAN: st_nxt.rdata = {30'h0, st_r.cap[1:0]};
            OFS_GRX: begin
              st_nxt.rdata = {24'h0, grx_byte};
              st_nxt.rx_pop = 1'b1;
              st_nxt.rx_ch = st_r.cap[1:0];
            end
            OFS_STAT: st_nxt.rdata = {30'h0, st_r.stat};
            OFS_MASK: st_nxt.rdata = {30'h0, st_r.mask};
            default: st_nxt.rdata = '0;
          endcase
        end
      end
    endcase
    // Set wins over a same cycle clear
    st_nxt.stat = (st_r.stat & ~clr) | set;
    st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hreadyout = st_r.hready;
  assign hrdata = st_r.rdata;
  assign hresp = 1'b0;
  assign irq_request = st_r.req;
  assign irq = st_r.irq;
  assign vector = st_r.vec;
  assign rx_pop = st_r.rx_pop;
  assign rx_pop_ch = st_r.rx_ch;
  assign tx_push = st_r.tx_push;
  assign tx_push_ch = st_r.tx_ch;
  assign tx_push_data = st_r.tx_data;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_req_thr;
    over |=> irq_request;
  endproperty
  a_req_thr: assert property (p_req_thr) else $error("Request missing above threshold");

  property p_no_req;
    (win[BID_W-1:2] <= st_r.thr) |=> !irq_request;
  endproperty
  a_no_req: assert property (p_no_req) else $error("Request raised at threshold");

  property p_cap_hold;
    !cap_ev |=> $stable(st_r.cap);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("Capture changed without cause");

  property p_ack_cap;
    $fell(intr_acknowledge_low) |=> st_r.cap == $past(win_gated) && st_r.stat[STAT_CAP];
  endproperty
  a_ack_cap: assert property (p_ack_cap) else $error("Acknowledge did not capture");

  property p_rx_err;
    rx_nonempty[2] && rx_error[2] && st_r.src_en[2] |-> bid[2][4:0] == 5'h1e;
  endproperty
  a_rx_err: assert property (p_rx_err) else $error("Bad error receiver bid");

  property p_rx_ok;
    rx_nonempty[1] && !rx_error[1] && st_r.src_en[1] |-> bid[1][4:0] == 5'h0d;
  endproperty
  a_rx_ok: assert property (p_rx_ok) else $error("Bad receiver bid");

  property p_idle_src;
    !rx_nonempty[3] && !tx_not_full[3] && !ct_timeout[1] |->
      bid[3] == '0 && bid[7] == '0 && bid[17] == '0;
  endproperty
  a_idle_src: assert property (p_idle_src) else $error("Idle source bid");

  property p_tx_fmt;
    tx_not_full[0] && st_r.src_en[4] |-> !bid[4][7] && bid[4][3:0] == 4'h8;
  endproperty
  a_tx_fmt: assert property (p_tx_fmt) else $error("Bad transmitter bid");

  property p_gchan;
    drd && st_r.addr == OFS_GCHAN |=> hreadyout && hrdata == {30'h0, $past(st_r.cap[1:0])};
  endproperty
  a_gchan: assert property (p_gchan) else $error("Global channel read wrong");

  property p_gtx;
    dwr && st_r.addr == OFS_GTX |=>
      tx_push && tx_push_ch == $past(st_r.cap[1:0]) && tx_push_data == $past(hwdata[7:0]);
  endproperty
  a_gtx: assert property (p_gtx) else $error("Global transmit write misrouted");

  property p_grx;
    drd && st_r.addr == OFS_GRX |=> rx_pop && hrdata[7:0] == $past(grx_byte);
  endproperty
  a_grx: assert property (p_grx) else $error("Global receive read misrouted");

  property p_vec;
    cap_ev && st_r.vmode == VM_CHAN |=> vector[1:0] == st_r.cap[1:0];
  endproperty
  a_vec: assert property (p_vec) else $error("Vector not modified");

  c_ack: cover property ($fell(intr_acknowledge_low) ##1 st_r.cap != '0);
  c_refresh: cover property (refresh ##1 st_r.cap != '0);
  c_grx: cover property (rx_pop);
  c_irq: cover property ($rose(irq));
endmodule // uib_bidding

`default_nettype wire

/* hdl/uib_pkg.sv */
// Constants and state type of the interrupt bidding block
package uib_pkg;
  localparam int NUM_CH = 4;
  localparam int NUM_CT = 2;
  localparam int BID_W = 8;
  localparam int THR_W = 6;
  localparam int PRIO_W = 20;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRIO = 8'h04;
  localparam logic [7:0] OFS_SRC_EN = 8'h08;
  localparam logic [7:0] OFS_CAP = 8'h0c;
  localparam logic [7:0] OFS_GBYTE = 8'h10;
  localparam logic [7:0] OFS_GCHAN = 8'h14;
  localparam logic [7:0] OFS_GRX = 8'h18;
  localparam logic [7:0] OFS_GTX = 8'h1c;
  localparam logic [7:0] OFS_STAT = 8'h20;
  localparam logic [7:0] OFS_MASK = 8'h24;
  // Field positions
  localparam int CTRL_VMODE_LSB = 6;
  localparam int CTRL_VBASE_LSB = 8;
  localparam int PRIO_COS_LSB = 8;
  localparam int PRIO_CT_LSB = 16;
  localparam int STAT_REQ = 0;
  localparam int STAT_CAP = 1;
  // Hardwired bid codes and source enable reset value
  localparam logic [2:0] TYPE_BRK = 3'h4;
  localparam logic [2:0] TYPE_COS = 3'h1;
  localparam logic [2:0] TYPE_CT = 3'h5;
  localparam logic [1:0] RX_TAIL = 2'h3;
  localparam logic [1:0] TX_TAIL = 2'h2;
  localparam logic [17:0] SRC_EN_RST = 18'h3_ffff;

  typedef enum logic [1:0] {
    VM_NONE = 2'b00,
    VM_CHAN = 2'b01,
    VM_TYPE = 2'b10
  } uib_vmode_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } uib_bus_type;

  typedef struct packed {
    uib_bus_type ph;
    logic wr;
    logic [7:0] addr;
    logic hready;
    logic [31:0] rdata;
    logic [THR_W-1:0] thr;
    uib_vmode_type vmode;
    logic [7:0] vbase;
    logic [PRIO_W-1:0] prio;
    logic [17:0] src_en;
    logic [BID_W-1:0] cap;
    logic [7:0] vec;
    logic req;
    logic ack_d;
    logic [1:0] stat;
    logic [1:0] mask;
    logic irq;
    logic rx_pop;
    logic [1:0] rx_ch;
    logic tx_push;
    logic [1:0] tx_ch;
    logic [7:0] tx_data;
  } uib_state_type;

  localparam uib_state_type ST_RST = '{ph: BUS_IDLE, hready: 1'b1, ack_d: 1'b1,
    vmode: VM_NONE, src_en: SRC_EN_RST, default: '0};
endpackage

/* verification/uib_bidding_tb.sv */
// Self-checking testbench of the interrupt bidding block
`timescale 1ns/1ps
`default_nettype none
module uib_bidding_tb;
  import uib_pkg::*;
  logic clk, resetn, hsel, hwrite, hreadyout, hresp, irq_request, irq, rx_pop, tx_push;
  logic [31:0] haddr, hwdata, hrdata, rx_fifo_data;
  logic [1:0] htrans, rx_pop_ch, tx_push_ch, ct_timeout;
  logic [2:0] hsize;
  logic [7:0] vector, tx_push_data, rx_count;
  logic [3:0] rx_nonempty, rx_full, rx_error, tx_not_full, break_active, cos_active;
  logic [11:0] tx_free;
  logic intr_acknowledge_low;
  logic [9:0] push_seen = '1;
  logic [1:0] pop_seen = '1;
  int num_errors = 0;
  int checks_done = 0;

  uib_host_model i_host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hreadyout(hreadyout), .hrdata(hrdata),
    .intr_acknowledge_low(intr_acknowledge_low));

  uib_bidding i_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_nonempty(rx_nonempty),
    .rx_full(rx_full), .rx_error(rx_error), .rx_count(rx_count), .rx_fifo_data(rx_fifo_data),
    .tx_not_full(tx_not_full), .tx_free(tx_free), .break_active(break_active),
    .cos_active(cos_active), .ct_timeout(ct_timeout),
    .intr_acknowledge_low(intr_acknowledge_low), .irq_request(irq_request), .irq(irq),
    .vector(vector), .rx_pop(rx_pop), .rx_pop_ch(rx_pop_ch), .tx_push(tx_push),
    .tx_push_ch(tx_push_ch), .tx_push_data(tx_push_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (tx_push === 1'b1) push_seen <= {tx_push_ch, tx_push_data};
    if (rx_pop === 1'b1) pop_seen <= rx_pop_ch;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  // Sets every source input at once, then lets the bids settle
  task automatic src(input logic [3:0] rn, rf, re, input logic [7:0] rc,
                     input logic [3:0] tn, input logic [11:0] tf,
                     input logic [3:0] b, c, input logic [1:0] t);
    @(posedge clk);
    rx_nonempty <= rn;
    rx_full <= rf;
    rx_error <= re;
    rx_count <= rc;
    tx_not_full <= tn;
    tx_free <= tf;
    break_active <= b;
    cos_active <= c;
    ct_timeout <= t;
    repeat (3) @(posedge clk);
  endtask

  task automatic cap_chk(input logic [7:0] exp);
    wr(OFS_CAP, 32'h0000_0000);
    rdchk(OFS_CAP, {24'h00_0000, exp});
  endtask

  task automatic s_reset;
    rdchk(OFS_CTRL, 32'h0000_0000);
    rdchk(OFS_SRC_EN, 32'h0003_ffff);
    rdchk(8'h30, 32'h0000_0000);
    rdchk(OFS_CAP, 32'h0000_0000);
  endtask

  task automatic s_rx;
    src(4'h4, 4'h4, 4'h4, 8'h20, 4'h0, 12'h000, 4'h0, 4'h0, 2'h0);
    rdchk(OFS_CAP, 32'h0000_0000);
    cap_chk(8'hde);
    rdchk(OFS_GBYTE, 32'h0000_0002);
    rdchk(OFS_GCHAN, 32'h0000_0002);
    rdchk(OFS_GRX, 32'h0000_00c3);
    @(negedge clk);
    chk(pop_seen, 2'h2);
    src(4'h4, 4'h4, 4'h0, 8'h20, 4'h0, 12'h000, 4'h0, 4'h0, 2'h0);
    cap_chk(8'hce);
  endtask

  task automatic s_tie;
    src(4'ha, 4'h0, 4'h0, 8'h44, 4'h0, 12'h000, 4'h0, 4'h0, 2'h0);
    cap_chk(8'h2f);
    chk(irq_request, 1'b1);
    wr(OFS_CTRL, 32'h0000_000b);
    repeat (3) @(posedge clk);
    chk(irq_request, 1'b0);
    cap_chk(8'h00);
    wr(OFS_CTRL, 32'h0000_000a);
    repeat (3) @(posedge clk);
    chk(irq_request, 1'b1);
    wr(OFS_CTRL, 32'h0000_0000);
  endtask

  task automatic s_tx;
    src(4'h0, 4'h0, 4'h0, 8'h00, 4'h1, 12'h005, 4'h0, 4'h0, 2'h0);
    cap_chk(8'h58);
    rdchk(OFS_GBYTE, 32'h0000_0005);
    wr(OFS_GTX, 32'h0000_00a5);
    @(negedge clk);
    chk(push_seen, 10'h0a5);
  endtask

  task automatic s_other;
    wr(OFS_PRIO, 32'h0008_010c);
    src(4'h0, 4'h0, 4'h0, 8'h00, 4'h0, 12'h000, 4'h2, 4'h0, 2'h0);
    cap_chk(8'hf1);
    src(4'h0, 4'h0, 4'h0, 8'h00, 4'h0, 12'h000, 4'h0, 4'h1, 2'h0);
    cap_chk(8'ha4);
    src(4'h0, 4'h0, 4'h0, 8'h00, 4'h0, 12'h000, 4'h0, 4'h0, 2'h2);
    cap_chk(8'h95);
    src(4'h0, 4'hf, 4'hf, 8'hff, 4'h0, 12'hfff, 4'h0, 4'h0, 2'h0);
    cap_chk(8'h00);
  endtask

  task automatic s_ack;
    wr(OFS_CTRL, 32'h0000_4040);
    src(4'h0, 4'h0, 4'h0, 8'h00, 4'h0, 12'h000, 4'h2, 4'h0, 2'h0);
    i_host.ack(1'b0);
    repeat (2) @(posedge clk);
    rdchk(OFS_CAP, 32'h0000_00f1);
    chk(vector, 8'h41);
    src(4'h0, 4'h0, 4'h0, 8'h00, 4'h0, 12'h000, 4'h0, 4'h1, 2'h0);
    rdchk(OFS_CAP, 32'h0000_00f1);
    i_host.ack(1'b1);
    wr(OFS_CTRL, 32'h0000_4080);
    cap_chk(8'ha4);
    chk(vector, 8'h44);
  endtask

  task automatic s_irq;
    src(4'h0, 4'h0, 4'h0, 8'h00, 4'h0, 12'h000, 4'h0, 4'h0, 2'h0);
    wr(OFS_MASK, 32'h0000_0001);
    wr(OFS_STAT, 32'h0000_0003);
    chk(irq, 1'b0);
    src(4'h1, 4'h0, 4'h0, 8'h00, 4'h0, 12'h000, 4'h0, 4'h0, 2'h0);
    chk(irq, 1'b1);
    rdchk(OFS_STAT, 32'h0000_0001);
    wr(OFS_STAT, 32'h0000_0001);
    chk(irq, 1'b0);
    wr(OFS_MASK, 32'h0000_0000);
  endtask

  task automatic end_sim;
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #500000;
    num_errors++;
    end_sim;
  end

  initial begin
    resetn = 1'b0;
    rx_fifo_data = 32'h00c3_0000;
    {rx_nonempty, rx_full, rx_error, tx_not_full, break_active, cos_active} = '0;
    {rx_count, tx_free, ct_timeout} = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    s_reset();
    s_rx();
    s_tie();
    s_tx();
    s_other();
    s_ack();
    s_irq();
    end_sim;
  end
endmodule // uib_bidding_tb
`default_nettype wire

/* verification/uib_host_model.sv */
// Host processor model: AHB-Lite master and interrupt acknowledge driver
`timescale 1ns/1ps
`default_nettype none
module uib_host_model (
  // Clock
  input wire logic clk,
  // AHB-Lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  // Interrupt acknowledge
  output logic intr_acknowledge_low
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    intr_acknowledge_low = 1'b1;
  end

  // Single word transfer; waits on ready in both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask

  task automatic ack(input logic v);
    @(posedge clk);
    intr_acknowledge_low <= v;
  endtask
endmodule // uib_host_model
`default_nettype wire
